// File: src/timer_flags_pkg.sv
package timer_flags_pkg;

   // Counter geometry
   localparam int CNT_W = 16;
   localparam int NUM_CH = 6;
   localparam logic [15:0] CNT_ZERO = 16'h0000;
   localparam logic [15:0] CNT_FULL = 16'hffff;
   localparam logic [15:0] MOD_NONE = 16'h0000;

   // Reset values
   localparam logic RST_FLAG = 1'b0;
   localparam logic RST_ARMED = 1'b0;
   localparam logic RST_DIR_DOWN = 1'b0;
   localparam logic [1:0] RST_SYNC = 2'h0;

   // Edge select field positions within the two-bit select
   localparam int EDGE_SEL_HIGH_BIT = 1;
   localparam int EDGE_SEL_LOW_BIT = 0;

   // Channel modes
   typedef enum logic [1:0] {
      MODE_CAPTURE,
      MODE_COMPARE,
      MODE_EDGE_PWM
   } ch_mode_e;

   // Next flag value: a new event always wins over the clear
   function automatic logic flag_next(input logic flag, input logic armed,
                                      input logic evt, input logic wr_zero);
      flag_next = evt | (flag & ~(wr_zero & armed));
   endfunction

   // Next arm state: a read of a set flag arms, an event disarms
   function automatic logic armed_next(input logic flag, input logic armed,
                                       input logic evt, input logic rd,
                                       input logic wr_zero);
      if (evt)
      begin
         armed_next = 1'b0;
      end
      else if (rd && flag)
      begin
         armed_next = 1'b1;
      end
      else if (wr_zero)
      begin
         armed_next = 1'b0;
      end
      else
      begin
         armed_next = armed;
      end
   endfunction

endpackage

// File: src/timer_channel_event.sv
`timescale 1ns/1ns
module timer_channel_event
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Counter state
   input wire logic i_tick,
   input wire logic i_center_aligned_pwm,
   input wire logic [15:0] i_count,
   // Channel configuration
   input wire timer_flags_pkg::ch_mode_e i_mode,
   input wire logic i_edge_select_high,
   input wire logic i_edge_select_low,
   input wire logic [15:0] i_value,
   input wire logic i_channel_irq_enable,
   // Channel pin
   input wire logic i_pin,
   // Software flag access
   input wire logic i_flag_rd,
   input wire logic i_flag_wr_zero,
   // Results
   output logic o_channel_event_flag,
   output logic o_irq,
   output logic [15:0] o_capture
);

   logic [1:0] sync_r;
   logic [1:0] sync_nxt;
   logic pin_prev_r;
   logic pin_prev_nxt;
   logic flag_r;
   logic flag_nxt;
   logic armed_r;
   logic armed_nxt;
   logic [15:0] capture_r;
   logic [15:0] capture_nxt;
   logic rise;
   logic fall;
   logic edge_hit;
   logic match;
   logic evt;

   ////////////////////////////////////////////////////////////////////////
   // Event detection
   always_comb
   begin
      sync_nxt = {sync_r[0], i_pin};
      pin_prev_nxt = sync_r[1];
      rise = sync_r[1] & ~pin_prev_r;
      fall = ~sync_r[1] & pin_prev_r;
      // Select 00 means capture off
      unique case ({i_edge_select_high, i_edge_select_low}) // R4
         2'h1: edge_hit = rise;
         2'h2: edge_hit = fall;
         2'h3: edge_hit = rise | fall;
         2'h0: edge_hit = 1'b0;
      endcase
      // Match only on an advancing cycle, so one visit gives one event
      match = i_tick && (i_count == i_value); // R12
      if (i_center_aligned_pwm)
      begin
         evt = match; // R8
      end
      else
      begin
         unique case (i_mode)
            timer_flags_pkg::MODE_CAPTURE: evt = edge_hit; // R5
            timer_flags_pkg::MODE_COMPARE: evt = match; // R6
            timer_flags_pkg::MODE_EDGE_PWM: evt = match; // R7
            default: evt = 1'b0;
         endcase
      end
      capture_nxt = (evt && !i_center_aligned_pwm &&
                     i_mode == timer_flags_pkg::MODE_CAPTURE) ?
                    i_count : capture_r;
      flag_nxt = timer_flags_pkg::flag_next(flag_r, armed_r, evt,
                                            i_flag_wr_zero); // R10
      armed_nxt = timer_flags_pkg::armed_next(flag_r, armed_r, evt,
                                              i_flag_rd, i_flag_wr_zero);
   end

   ////////////////////////////////////////////////////////////////////////
   // State registers
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         sync_r <= timer_flags_pkg::RST_SYNC;
         pin_prev_r <= 1'b0;
         flag_r <= timer_flags_pkg::RST_FLAG;
         armed_r <= timer_flags_pkg::RST_ARMED;
         capture_r <= timer_flags_pkg::CNT_ZERO;
      end
      else
      begin
         sync_r <= sync_nxt;
         pin_prev_r <= pin_prev_nxt;
         flag_r <= flag_nxt;
         armed_r <= armed_nxt;
         capture_r <= capture_nxt;
      end
   end

   // Level request while enabled and set
   assign o_irq = flag_r & i_channel_irq_enable; // R11
   assign o_channel_event_flag = flag_r;
   assign o_capture = capture_r;

endmodule // timer_channel_event

// File: src/timer_event_flag_logic.sv
`timescale 1ns/1ns
// Behaviour
// [R1] Free-run up count 0000..ffff wraps to 0000, setting the wrap flag.
// [R2] With a modulus, wrap flag sets on modulus-to-0000 transition.
// [R3] Up/down mode sets wrap flag when stepping down from the modulus.
// [R4] Two edge-select bits choose rising, falling, both or no capture edge.
// [R5] Input capture sets channel flag on each selected edge.
// [R6] Output compare sets channel flag on each tick that finds counter equal to compare value.
// [R7] Edge PWM sets channel flag on compare match, end of duty.
// [R8] Center PWM sets channel flag on both matches per period.
// [R9] Software clears flags by read-then-write-zero, never a single write.
// [R10] Clear needs read while set then zero write; new event keeps flag.
// [R11] Enabled flag holds a level interrupt request while it is one.
// [R12] Flags evaluate only on advancing or sampled cycles, once per event.
module timer_event_flag_logic
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Counter control
   input wire logic i_count_tick,
   input wire logic i_center_aligned_pwm,
   input wire logic [15:0] i_modulus,
   input wire logic i_wrap_irq_enable,
   // Wrap flag access
   input wire logic i_wrap_flag_rd,
   input wire logic i_wrap_flag_wr_zero,
   // Channel configuration
   input wire timer_flags_pkg::ch_mode_e i_ch_mode [timer_flags_pkg::NUM_CH],
   input wire logic [5:0] i_edge_select_high,
   input wire logic [5:0] i_edge_select_low,
   input wire logic [15:0] i_ch_value [timer_flags_pkg::NUM_CH],
   input wire logic [5:0] i_channel_irq_enable,
   // Channel pins
   input wire logic [5:0] i_ch_pin,
   // Channel flag access
   input wire logic [5:0] i_ch_flag_rd,
   input wire logic [5:0] i_ch_flag_wr_zero,
   // Counter and flags
   output logic [15:0] o_count,
   output logic o_count_down,
   output logic o_counter_wrap_flag,
   output logic [5:0] o_channel_event_flag,
   output logic [15:0] o_capture [timer_flags_pkg::NUM_CH],
   // Interrupt requests
   output logic o_wrap_irq,
   output logic [5:0] o_channel_irq
);

   // Counter state
   logic [15:0] count_r;
   logic [15:0] count_nxt;
   logic down_r;
   logic down_nxt;

   // Wrap flag state
   logic wrap_flag_r;
   logic wrap_flag_nxt;
   logic wrap_armed_r;
   logic wrap_armed_nxt;

   // Decoded counter conditions
   logic [15:0] limit;
   logic wrap_evt;

   ////////////////////////////////////////////////////////////////////////
   // Limit test shared by both counting modes; >= also catches a count
   // left above a modulus that was lowered while running
   function automatic logic at_limit(input logic [15:0] count,
                                     input logic [15:0] lim);
      at_limit = (count >= lim);
   endfunction

   // Single steps; the carry or borrow is dropped on purpose
   function automatic logic [15:0] step_up(input logic [15:0] count);
      step_up = count + 16'h0001;
   endfunction

   function automatic logic [15:0] step_down(input logic [15:0] count);
      step_down = count - 16'h0001;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Effective limit: a zero modulus means the full 16-bit range
   always_comb
   begin
      limit = (i_modulus == timer_flags_pkg::MOD_NONE) ?
              timer_flags_pkg::CNT_FULL : i_modulus;
   end

   ////////////////////////////////////////////////////////////////////////
   // Counter and wrap event
   always_comb
   begin
      count_nxt = count_r;
      down_nxt = down_r;
      wrap_evt = 1'b0;
      if (i_count_tick) // R12
      begin
         if (!i_center_aligned_pwm)
         begin
            down_nxt = 1'b0;
            if (at_limit(count_r, limit))
            begin
               // Also recovers if the modulus drops below the count
               count_nxt = timer_flags_pkg::CNT_ZERO;
               wrap_evt = 1'b1; // R1 R2
            end
            else
            begin
               count_nxt = step_up(count_r);
            end
         end
         else if (!down_r)
         begin
            if (at_limit(count_r, limit))
            begin
               // Turn at the modulus: this is the period end
               count_nxt = step_down(count_r);
               down_nxt = 1'b1;
               wrap_evt = 1'b1; // R3
            end
            else
            begin
               count_nxt = step_up(count_r);
            end
         end
         else
         begin
            if (count_r == timer_flags_pkg::CNT_ZERO)
            begin
               // Zero is the period centre, no flag here
               count_nxt = step_up(count_r);
               down_nxt = 1'b0;
            end
            else
            begin
               count_nxt = step_down(count_r);
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Wrap flag next state; a wrap in the clear cycle keeps the flag set
   always_comb
   begin
      wrap_flag_nxt = timer_flags_pkg::flag_next(wrap_flag_r, wrap_armed_r,
                         wrap_evt, i_wrap_flag_wr_zero); // R10
      wrap_armed_nxt = timer_flags_pkg::armed_next(wrap_flag_r,
                          wrap_armed_r, wrap_evt, i_wrap_flag_rd,
                          i_wrap_flag_wr_zero); // R10
   end

   ////////////////////////////////////////////////////////////////////////
   // Counter registers
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         count_r <= timer_flags_pkg::CNT_ZERO;
         down_r <= timer_flags_pkg::RST_DIR_DOWN;
      end
      else
      begin
         count_r <= count_nxt;
         down_r <= down_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Wrap flag registers
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         wrap_flag_r <= timer_flags_pkg::RST_FLAG;
         wrap_armed_r <= timer_flags_pkg::RST_ARMED;
      end
      else
      begin
         wrap_flag_r <= wrap_flag_nxt;
         wrap_armed_r <= wrap_armed_nxt;
      end
   end

   // Outputs straight from the registers
   assign o_count = count_r;
   assign o_count_down = down_r;
   assign o_counter_wrap_flag = wrap_flag_r;
   // Level request follows flag and enable with no extra delay
   assign o_wrap_irq = wrap_flag_r & i_wrap_irq_enable; // R11

   ////////////////////////////////////////////////////////////////////////
   // Channels; all see the pre-update count, so a match is taken
   // on the same edge that moves the counter
   genvar ch;
   generate
      for (ch = 0; ch < timer_flags_pkg::NUM_CH; ch++)
      begin : g_ch
         timer_channel_event u_ch
         (
            .i_clk(i_clk),
            .i_rst_n(i_rst_n),
            .i_tick(i_count_tick),
            .i_center_aligned_pwm(i_center_aligned_pwm),
            .i_count(count_r),
            .i_mode(i_ch_mode[ch]),
            .i_edge_select_high(i_edge_select_high[ch]),
            .i_edge_select_low(i_edge_select_low[ch]),
            .i_value(i_ch_value[ch]),
            .i_channel_irq_enable(i_channel_irq_enable[ch]),
            .i_pin(i_ch_pin[ch]),
            .i_flag_rd(i_ch_flag_rd[ch]),
            .i_flag_wr_zero(i_ch_flag_wr_zero[ch]),
            .o_channel_event_flag(o_channel_event_flag[ch]),
            .o_irq(o_channel_irq[ch]),
            .o_capture(o_capture[ch])
         );
      end
   endgenerate

endmodule // timer_event_flag_logic

// File: testbench/timer_event_flag_logic_asserts.sv
`timescale 1ns/1ns
module timer_event_flag_logic_asserts
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Inputs watched
   input wire logic i_count_tick,
   input wire logic i_center_aligned_pwm,
   input wire logic [15:0] i_modulus,
   input wire logic i_wrap_irq_enable,
   input wire logic i_wrap_flag_rd,
   input wire logic i_wrap_flag_wr_zero,
   input wire logic [5:0] i_channel_irq_enable,
   input wire logic [5:0] i_ch_flag_wr_zero,
   // Outputs watched
   input wire logic [15:0] o_count,
   input wire logic o_count_down,
   input wire logic o_counter_wrap_flag,
   input wire logic [5:0] o_channel_event_flag,
   input wire logic o_wrap_irq,
   input wire logic [5:0] o_channel_irq
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_n);
   ////////////////////////////////////////////////////////////////////////
   // Clear steps; ticks excluded so no new event can interfere
   sequence s_armed;
      o_counter_wrap_flag && i_wrap_flag_rd && !i_count_tick;
   endsequence
   sequence s_write;
      i_wrap_flag_wr_zero && !i_count_tick;
   endsequence
   // Flag may land one cycle after the count
   a_wrap_free_run: assert property (
      i_count_tick && !i_center_aligned_pwm && i_modulus == 16'h0000
      && o_count == 16'hffff |=> o_count == 16'h0000 ##[0:1]
      o_counter_wrap_flag) else $error("free run wrap wrong");
   a_wrap_at_mod: assert property (
      i_count_tick && !i_center_aligned_pwm && i_modulus != 16'h0000
      && o_count == i_modulus |=> o_count == 16'h0000 ##[0:1]
      o_counter_wrap_flag) else $error("modulus wrap wrong");
   a_updown_turn: assert property (
      i_count_tick && i_center_aligned_pwm && !o_count_down
      && i_modulus != 16'h0000 && o_count == i_modulus |=> o_count_down
      && o_count == $past(i_modulus) - 16'h0001 ##[0:1]
      o_counter_wrap_flag) else $error("direction turn wrong");
   a_hold_no_tick: assert property (
      !i_count_tick |=> $stable(o_count) && $stable(o_count_down))
      else $error("count moved without tick");
   a_wrap_irq_level: assert property (
      o_wrap_irq == (o_counter_wrap_flag & i_wrap_irq_enable))
      else $error("wrap request wrong");
   a_ch_irq_level: assert property (
      o_channel_irq == (o_channel_event_flag & i_channel_irq_enable))
      else $error("channel request wrong");
   a_fall_needs_write: assert property (
      $fell(o_counter_wrap_flag) |-> $past(i_wrap_flag_wr_zero))
      else $error("flag fell without write");
   a_flag_sticky: assert property (
      o_counter_wrap_flag && !i_wrap_flag_wr_zero |=> o_counter_wrap_flag)
      else $error("flag lost");
   a_clear_two_step: assert property (
      s_armed ##1 s_write |=> !o_counter_wrap_flag)
      else $error("clear sequence failed");
   a_ch_fall_write: assert property (
      (~o_channel_event_flag & $past(o_channel_event_flag)
      & ~$past(i_ch_flag_wr_zero)) == 6'h00)
      else $error("channel flag fell without write");
endmodule // timer_event_flag_logic_asserts

bind timer_event_flag_logic timer_event_flag_logic_asserts u_chk
(
   .i_clk, .i_rst_n, .i_count_tick, .i_center_aligned_pwm, .i_modulus,
   .i_wrap_irq_enable, .i_wrap_flag_rd, .i_wrap_flag_wr_zero,
   .i_channel_irq_enable, .i_ch_flag_wr_zero, .o_count, .o_count_down,
   .o_counter_wrap_flag, .o_channel_event_flag, .o_wrap_irq, .o_channel_irq
);

// File: testbench/timer_event_flag_logic_tb.sv
`timescale 1ns/1ns
module timer_event_flag_logic_tb;
   // Stimulus and observed values
   logic i_clk, i_rst_n, tick, center_aligned_pwm, wien, wrd, wwr, down, wfl, wirq;
   logic [15:0] modv, cnt;
   logic [5:0] esh, esl, cien, pin, crd, cwr, fl, cirq;
   timer_flags_pkg::ch_mode_e mode [timer_flags_pkg::NUM_CH];
   logic [15:0] val [timer_flags_pkg::NUM_CH];
   logic [15:0] cap [timer_flags_pkg::NUM_CH];
   int n_errors = 0;
   int check_count = 0;

   timer_event_flag_logic dut
   (
      .i_clk(i_clk), .i_rst_n(i_rst_n), .i_count_tick(tick),
      .i_center_aligned_pwm(center_aligned_pwm), .i_modulus(modv),
      .i_wrap_irq_enable(wien), .i_wrap_flag_rd(wrd),
      .i_wrap_flag_wr_zero(wwr), .i_ch_mode(mode),
      .i_edge_select_high(esh), .i_edge_select_low(esl),
      .i_ch_value(val), .i_channel_irq_enable(cien), .i_ch_pin(pin),
      .i_ch_flag_rd(crd), .i_ch_flag_wr_zero(cwr), .o_count(cnt),
      .o_count_down(down), .o_counter_wrap_flag(wfl),
      .o_channel_event_flag(fl), .o_capture(cap), .o_wrap_irq(wirq),
      .o_channel_irq(cirq)
   );
   ////////////////////////////////////////////////////////////////////////
   // Clock at 8 ns
   initial
   begin
      i_clk = 1'b0;
      forever #4 i_clk = ~i_clk;
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Inputs move 1 ns after the edge so sampling never races
   task automatic step(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask
   // Extra idle cycle lets late flags land before checks
   task automatic ticks(input int n);
      tick = 1'b1;
      step(n);
      tick = 1'b0;
      step(1);
   endtask
   task automatic rst();
      i_rst_n = 1'b0;
      step(3);
      i_rst_n = 1'b1;
   endtask
   // Bit 6 selects the wrap flag, bits 5..0 the channels
   task automatic clr(input logic [6:0] m, input logic rd);
      {wrd, crd} = rd ? m : 7'h00;
      step(1);
      {wrd, crd} = 7'h00;
      {wwr, cwr} = m;
      step(1);
      {wwr, cwr} = 7'h00;
      step(1);
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Ch3 rise, ch4 fall, ch5 both, ch0..2 off
   task automatic t_cap();
      {esh, esl} = {6'h30, 6'h28};
      pin = 6'h3f;
      step(4);
      chk(16'(fl), 16'h0028);
      chk(cap[3], 16'h0000);
      pin = 6'h00;
      step(4);
      chk(16'(fl), 16'h0038);
      cien = 6'h3f;
      #1 chk(16'(cirq), 16'h0038);
      $display("capture test done");
   endtask
   task automatic t_free();
      ticks(65536);
      chk(cnt, 16'h0000);
      chk(16'(wfl), 16'h0001);
      chk(16'(wirq), 16'h0000);
      wien = 1'b1;
      #1 chk(16'(wirq), 16'h0001);
      clr(7'h40, 1'b0);
      chk(16'(wfl), 16'h0001);
      clr(7'h78, 1'b1);
      chk(16'({wfl, fl, wirq}), 16'h0000);
      $display("free run test done");
   endtask
   task automatic t_mod();
      rst();
      mode[0] = timer_flags_pkg::MODE_COMPARE;
      val[0] = 16'h0002;
      mode[1] = timer_flags_pkg::MODE_EDGE_PWM;
      val[1] = 16'h0001;
      modv = 16'h0003;
      ticks(3);
      chk(16'({wfl, fl}), 16'h0003);
      ticks(1);
      chk(cnt, 16'h0000);
      chk(16'(wfl), 16'h0001);
      // New match between read and write keeps the flag
      crd = 6'h01;
      step(1);
      crd = 6'h00;
      ticks(3);
      clr(7'h01, 1'b0);
      chk(16'(fl[0]), 16'h0001);
      clr(7'h01, 1'b1);
      val[0] = 16'h0003;
      step(3);
      chk(16'(fl[0]), 16'h0000);
      // Capture while the count stands at 3 latches that count
      pin = 6'h08;
      step(4);
      chk(cap[3], 16'h0003);
      chk(16'(fl[3]), 16'h0001);
      $display("modulus test done");
   endtask
   task automatic t_cen();
      rst();
      {center_aligned_pwm, val[2]} = {1'b1, 16'h0001};
      ticks(2);
      chk(16'(fl[2]), 16'h0001);
      clr(7'h04, 1'b1);
      ticks(2);
      chk(16'({down, wfl, fl[2]}), 16'h0006);
      chk(cnt, 16'h0002);
      ticks(2);
      chk(16'(fl[2]), 16'h0001);
      // Turning up again at zero is the centre, no wrap flag there
      clr(7'h40, 1'b1);
      ticks(1);
      chk(16'({down, wfl}), 16'h0000);
      chk(cnt, 16'h0001);
      $display("center test done");
   endtask
   task automatic complete_run();
      $display("checks=%0d errors=%0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Hang guard
   initial
   begin
      #700000;
      n_errors++;
      complete_run();
   end
   // Main sequence
   initial
   begin
      {tick, center_aligned_pwm, wien, wrd, wwr, modv} = 21'h000000;
      {esh, esl, cien, pin, crd, cwr} = 36'h000000000;
      foreach (mode[k])
      begin
         mode[k] = timer_flags_pkg::MODE_CAPTURE;
         val[k] = 16'h0000;
      end
      rst();
      t_cap();
      t_free();
      t_mod();
      t_cen();
      complete_run();
   end
endmodule // timer_event_flag_logic_tb
